/* File: bench/cop_chk_sva.sv */
// port-level assertions for the otp key programmer
// assumes one clock i_clk and asynchronous active-high i_sys_rst; bound into every cop_top
`timescale 1ns/1ps
`default_nettype none
module cop_chk_sva #(
    parameter int TXTB_W = 128
) (
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [7:0]        i_paddr,
    input wire logic              i_module_disable,
    input wire logic              i_block_done,
    input wire logic              o_key_valid,
    input wire logic [127:0]      o_session_key,
    input wire logic [3:0]        o_key_source,
    input wire logic [8:0]        o_aes_key_bits,
    input wire logic [1:0]        o_des_key_count,
    input wire logic              o_key_len_reserved,
    input wire logic [TXTB_W-1:0] o_text_b,
    input wire logic              o_otp_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic ctl_evt;
    logic apb_wr;
    assign apb_wr  = i_psel && i_penable && i_pwrite;
    assign ctl_evt = (apb_wr && i_paddr == 8'h04) || i_module_disable;
    // control-high copies lag the write by up to two edges
    sequence s_ctl_recent;
        $past(ctl_evt) || $past(ctl_evt, 2);
    endsequence
    sequence s_busy_recent;
        $past(o_otp_busy) || $past(o_otp_busy, 2);
    endsequence
    sequence s_two_disabled;
        i_module_disable ##1 i_module_disable;
    endsequence
    AST_AES_SIZES: assert property (o_aes_key_bits == 9'h000 || o_aes_key_bits == 9'h080
        || o_aes_key_bits == 9'h0C0 || o_aes_key_bits == 9'h100) else $error("aes key size off the code table");
    AST_AES_ALONE: assert property (o_aes_key_bits != 9'h000 |-> o_des_key_count == 2'h0 && !o_key_len_reserved)
        else $error("aes size shown with another key code");
    AST_DES_ALONE: assert property (o_des_key_count != 2'h0 |-> o_aes_key_bits == 9'h000 && !o_key_len_reserved)
        else $error("des count shown with another key code");
    AST_RSV_CODE: assert property (o_key_len_reserved |-> o_aes_key_bits == 9'h000 && o_des_key_count == 2'h0)
        else $error("reserved key code still gives a key size");
    AST_TEXTB_HOLD: assert property (!i_block_done && !apb_wr |=> $stable(o_text_b))
        else $error("text b moved without block done or write");
    AST_KEY_LOADED: assert property ($rose(o_key_valid) |-> s_busy_recent)
        else $error("key valid rose without a reload");
    AST_KSRC_CAUSE: assert property ($changed(o_key_source) |-> s_ctl_recent)
        else $error("key source changed without control write");
    AST_SKEY_CAUSE: assert property ($changed(o_session_key) |-> s_ctl_recent or s_busy_recent)
        else $error("session key changed without cause");
    AST_DISABLE_CLR: assert property (s_two_disabled |=> o_key_source == 4'h0 && !o_key_valid && !o_otp_busy)
        else $error("module disable left state behind");
endmodule // cop_chk_sva
bind cop_top cop_chk_sva #(.TXTB_W(TXTB_W)) u_cop_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_module_disable(i_module_disable),
    .i_block_done(i_block_done), .o_key_valid(o_key_valid), .o_session_key(o_session_key),
    .o_key_source(o_key_source), .o_aes_key_bits(o_aes_key_bits), .o_des_key_count(o_des_key_count),
    .o_key_len_reserved(o_key_len_reserved), .o_text_b(o_text_b), .o_otp_busy(o_otp_busy));
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for cop_top: apb traffic, otp program and reload, counter, interrupt, disable
// assumes cop_map.vh on the include path; a short program count keeps the run brief, the read count stays at its default of 4
`timescale 1ns/1ps
`default_nettype none
`include "cop_map.vh"
module tb_top;
    typedef struct packed {logic [31:0] e; logic [31:0] m; logic err;} cop_note_t;
    logic         i_clk, i_sys_rst, psel, penable, pwrite, mdis, bdone, pready, pslverr, irq, kval, kres, busy, ie;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, seed, va, vb;
    logic [127:0] skey, textb;
    logic [3:0]   ksrc;
    logic [8:0]   aesb;
    logic [1:0]   desc;
    logic [63:0]  kp [1:4];
    logic [8:0]   aes_t [4] = '{9'h080, 9'h0C0, 9'h100, 9'h000};
    logic [1:0]   des_t [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    cop_note_t    notes [$];
    int           error_cnt = 0, check_count = 0, cyc = 0;
    cop_top #(.PAGES(16), .TXTB_W(128), .PROG_CYC(3), .READ_CYC(4)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_module_disable(mdis),
        .i_block_done(bdone), .o_irq(irq), .o_key_valid(kval), .o_session_key(skey), .o_key_source(ksrc),
        .o_aes_key_bits(aesb), .o_des_key_count(desc), .o_key_len_reserved(kres), .o_text_b(textb),
        .o_otp_busy(busy));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic err = 1'b0);
        notes.push_back('{e, m, err});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // lets registered outputs with one cycle of lag land before they are looked at
    task automatic settle;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic idle;
        repeat (2) @(posedge i_clk);
        while (busy !== 1'b0) @(posedge i_clk);
    endtask
    task automatic prog(input logic [3:0] pg, input logic [63:0] d);
        wr(`COP_A_OTP, {25'h0, ie, 2'h0, pg});
        wr(`COP_A_TXTC0, d[31:0]);
        wr(`COP_A_TXTC1, d[63:32]);
        wr(`COP_A_OTP, {25'h0, ie, 2'h1, pg});
        settle();
        chk("otp busy", 1'b1, busy);
        idle();
    endtask
    task automatic reload;
        wr(`COP_A_OTP, {25'h0, ie, 6'h20});
        idle();
    endtask
    task automatic pulse;
        @(posedge i_clk);
        bdone <= 1'b1;
        @(posedge i_clk);
        bdone <= 1'b0;
    endtask
    // read results are compared as they appear, against the oldest note
    always @(posedge i_clk) begin : monitor
        cop_note_t n;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            n = notes.pop_front();
            chk("read data", n.e, prdata & n.m);
            chk("slave error", n.err, pslverr);
        end
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        {psel, penable, pwrite, mdis, bdone, ie} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        seed = 32'hCBBE;
        i_sys_rst = 1'b1;
        repeat (5) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(`COP_A_CONH, 32'h0, 32'hFFFF);
        rd(`COP_A_OTP, 32'h400, 32'hC30);
        wr(`COP_A_OTP, 32'h10);
        rd(`COP_A_OTP, 32'h400, 32'hC30);
        rd(8'h24, 32'h0, 32'hFFFF_FFFF, 1'b1);
        $display("test done: reset and refusal");
        wr(`COP_A_CTRL, 32'h1);
        rd(`COP_A_OTP, 32'h0, 32'h400);
        ie = 1'b1;
        va = rnd();
        prog(4'h0, {rnd(), va});
        rd(`COP_A_ISTAT, 32'h1, 32'h1);
        rd(`COP_A_OTP, 32'h0, 32'h10);
        vb = rnd();
        prog(4'h0, {rnd(), vb});
        reload();
        rd(`COP_A_CFG, va | vb, 32'hFFFF_FFFF);
        rd(`COP_A_OTP, 32'h0, 32'h20);
        settle();
        chk("key valid", 1'b1, kval);
        chk("irq", 1'b1, irq);
        ie = 1'b0;
        wr(`COP_A_OTP, 32'h0);
        settle();
        chk("irq", 1'b0, irq);
        wr(`COP_A_IEN, 32'h2);
        settle();
        chk("irq", 1'b1, irq);
        wr(`COP_A_ICLR, 32'hF);
        settle();
        chk("irq", 1'b0, irq);
        wr(`COP_A_OTP, 32'h100);
        rd(`COP_A_OTP, 32'h400, 32'h400);
        $display("test done: config page");
        for (int p = 1; p <= 4; p++) begin
            kp[p] = {rnd(), rnd()};
            prog(4'(p), kp[p]);
        end
        reload();
        settle();
        chk("session key", {kp[2], kp[1]}, skey);
        wr(`COP_A_CONH, 32'h85);
        settle();
        chk("session key", {kp[4], kp[3]}, skey);
        chk("key source", 4'h5, ksrc);
        $display("test done: key pages");
        wr(`COP_A_ICLR, 32'hF);
        wr(`COP_A_OTP, 32'h20);
        wr(`COP_A_CTRL, 32'h0);
        idle();
        rd(`COP_A_OTP, 32'h0, 32'h20);
        rd(`COP_A_ISTAT, 32'h0, 32'h2);
        chk("key valid", 1'b0, kval);
        wr(`COP_A_CTRL, 32'h1);
        reload();
        settle();
        chk("key valid", 1'b1, kval);
        wr(`COP_A_OTP, 32'h200);
        rd(`COP_A_OTP, 32'h80, 32'h280);
        $display("test done: abort and mark");
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                wr(`COP_A_CTRL, 32'(1 + 2 * c));
                wr(`COP_A_CONH, 32'(k * 32));
                settle();
                chk("aes bits", (c == 1) ? aes_t[k] : 9'h000, aesb);
                chk("des count", (c == 1) ? 2'h0 : des_t[k], desc);
                chk("reserved", (c == 1) ? (k == 3) : (k == 2), kres);
            end
        end
        wr(`COP_A_CONH, 32'hFFEF);
        rd(`COP_A_CONH, 32'h7FEF, 32'hFFFF);
        wr(`COP_A_CONH, 32'h10);
        rd(`COP_A_CONH, 32'h10, 32'h10);
        idle();
        rd(`COP_A_CONH, 32'h0, 32'h10);
        rd(`COP_A_ISTAT, 32'h8, 32'h8);
        chk("session key", 128'h0, skey);
        $display("test done: key length and erase");
        wr(`COP_A_CONH, 32'h300);
        wr(`COP_A_CTRL, 32'h5);
        va = rnd();
        va[3:0] = 4'hE;
        wr(`COP_A_TXTB0, va);
        pulse();
        rd(`COP_A_TXTB0, {va[31:4], 4'hF}, 32'hFFFF_FFFF);
        chk("text b", {va[31:4], 4'hF}, textb[31:0]);
        pulse();
        rd(`COP_A_TXTB0, {va[31:4], 4'h0}, 32'hFFFF_FFFF);
        rd(`COP_A_ISTAT, 32'h4, 32'h4);
        wr(`COP_A_CTRL, 32'h1);
        pulse();
        rd(`COP_A_TXTB0, {va[31:4], 4'h0}, 32'hFFFF_FFFF);
        $display("test done: counter");
        wr(`COP_A_CONH, 32'h85);
        @(posedge i_clk);
        mdis <= 1'b1;
        repeat (3) @(posedge i_clk);
        mdis <= 1'b0;
        rd(`COP_A_CONH, 32'h0, 32'hFFFF);
        rd(`COP_A_CTRL, 32'h0, 32'h7);
        settle();
        chk("key source", 4'h0, ksrc);
        chk("key valid", 1'b0, kval);
        $display("test done: module disable");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

/* File: logic/cop_map.vh */
// register map, field positions, reset values and timing figures for the otp key programmer
// assumes a 32-bit apb slave on a 100 MHz clock; all offsets are byte addresses
// Summary of operation
// - an illegal selection reports program fail high and refuses the programming.
// - programming only ORs in ones; zero bits stay free for a later pass.
// - config page takes text C bits 31:0, key pages take bits 63:0.
// - write-go starts programming, clears on completion, raises done interrupt if enabled.
// - reload-go reloads stored values and clears when the read is finished.
// - clearing enable during reload aborts it; enable plus reload-go recovers.
// - setting program-ok mark also sets program-ok status bit seven.
// - counter width acts only in counter mode, otherwise it has no effect.
// - aes key length codes 00 128, 01 192, 10 256, 11 reserved.
// - des key length codes 11 three-key, 10 reserved, 01 two-key, 00 single.
// - key ram erase is set-only, erases key ram, reads one until done.
`ifndef COP_MAP_VH
`define COP_MAP_VH
`define COP_A_CTRL      8'h00
`define COP_A_CONH      8'h04
`define COP_A_OTP       8'h08
`define COP_A_TXTC0     8'h0C
`define COP_A_TXTC1     8'h10
`define COP_A_ISTAT     8'h14
`define COP_A_IEN       8'h18
`define COP_A_ICLR      8'h1C
`define COP_A_CFG       8'h20
`define COP_A_TXTB0     8'h30
`define COP_A_TXTB1     8'h34
`define COP_A_TXTB2     8'h38
`define COP_A_TXTB3     8'h3C
`define COP_CTRL_EN     0
`define COP_CTRL_CIPH   1
`define COP_CTRL_CTRM   2
`define COP_OTP_PG_MSB  3
`define COP_OTP_PG_LSB  0
`define COP_OTP_WR      4
`define COP_OTP_RD      5
`define COP_OTP_IE      6
`define COP_OTP_OKST    7
`define COP_OTP_DEST    8
`define COP_OTP_MARK    9
`define COP_OTP_FAIL    10
`define COP_OTP_BUSY    11
`define COP_CH_CTR_MSB  14
`define COP_CH_CTR_LSB  8
`define COP_CH_SKEY     7
`define COP_CH_KM_MSB   6
`define COP_CH_KM_LSB   5
`define COP_CH_WIPE     4
`define COP_CH_KS_MSB   3
`define COP_CH_KS_LSB   0
`define COP_CONH_RST    16'h0000
`define COP_CONH_WMASK  16'h7FEF
`define COP_EV_WR       0
`define COP_EV_RD       1
`define COP_EV_ROLL     2
`define COP_EV_WIPE     3
`define COP_CLK_NS      10
`define COP_PROG_NS     10000
`define COP_READ_NS     40
`define COP_PAGE_CFG    4'h0
`define COP_KEY_PAGES   3'h4
`define COP_KEY_WORDS   2'h3
`endif

/* File: logic/cop_top.v */
// otp key/config programming sequencer with control high register, apb slave and interrupt
// assumes apb master on i_clk; i_module_disable and i_block_done come from logic on the same clock
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cop_map.vh"
module cop_top #(
    parameter PAGES    = 16,
    parameter TXTB_W   = 128,
    parameter PROG_CYC = (`COP_PROG_NS + `COP_CLK_NS - 1) / `COP_CLK_NS,
    parameter READ_CYC = (`COP_READ_NS + `COP_CLK_NS - 1) / `COP_CLK_NS
) (
    input  wire          i_clk,
    input  wire          i_sys_rst,
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [7:0]    i_paddr,
    input  wire [31:0]   i_pwdata,
    output reg  [31:0]   o_prdata,
    output wire          o_pready,
    output wire          o_pslverr,
    input  wire          i_module_disable,
    input  wire          i_block_done,
    output wire          o_irq,
    output reg           o_key_valid,
    output reg  [127:0]  o_session_key,
    output reg  [3:0]    o_key_source,
    output reg  [8:0]    o_aes_key_bits,
    output reg  [1:0]    o_des_key_count,
    output reg           o_key_len_reserved,
    output reg  [TXTB_W-1:0] o_text_b,
    output wire          o_otp_busy
);
    localparam ST_IDLE  = 2'b00;
    localparam ST_PROG  = 2'b01;
    localparam ST_LOAD  = 2'b10;
    localparam ST_WIPE  = 2'b11;

    reg  [63:0]  otp_mem [0:2*PAGES-1];
    reg  [63:0]  key_r   [0:3];
    reg  [1:0]   state_r;
    reg  [15:0]  cnt_r;
    reg  [2:0]   step_r;
    reg  [4:0]   addr_r;
    reg  [2:0]   ctrl_r;
    reg  [15:0]  conh_r;
    reg  [3:0]   page_r;
    reg          dest_r;
    reg          wr_go_r;
    reg          rd_go_r;
    reg          ie_r;
    reg          mark_r;
    reg  [63:0]  txtc_r;
    reg  [31:0]  cfg_r;
    reg  [3:0]   istat_r;
    reg  [3:0]   ien_r;
    reg  [3:0]   ev;
    reg  [TXTB_W-1:0] ctr_mask;
    reg  [TXTB_W-1:0] txtb_nxt;

    wire         wr_acc   = i_psel & i_penable & i_pwrite;
    wire         rd_acc   = i_psel & i_penable & ~i_pwrite;
    wire         en       = ctrl_r[`COP_CTRL_EN];
    wire         ctr_mode = ctrl_r[`COP_CTRL_CTRM];
    wire         is_cfg   = (page_r == `COP_PAGE_CFG);
    // config page lives in bank zero only; programming needs a live engine and a quiet sequencer
    wire         fail     = ~en | (is_cfg & dest_r) | rd_go_r | (state_r != ST_IDLE);
    wire         wr_otp   = wr_acc & (i_paddr == `COP_A_OTP);
    wire         wr_conh  = wr_acc & (i_paddr == `COP_A_CONH);
    wire [3:0]   ien_eff  = {ien_r[3:2], ien_r[1:0] | {2{ie_r}}};
    reg          hit;
    integer      blank_i;

    assign o_pready   = 1'b1;
    assign o_pslverr  = i_psel & i_penable & ~hit;
    assign o_irq      = |(istat_r & ien_eff);
    assign o_otp_busy = (state_r != ST_IDLE);

    always @* begin
        case (i_paddr)
            `COP_A_CTRL, `COP_A_CONH, `COP_A_OTP, `COP_A_TXTC0, `COP_A_TXTC1,
            `COP_A_ISTAT, `COP_A_IEN, `COP_A_ICLR, `COP_A_CFG,
            `COP_A_TXTB0, `COP_A_TXTB1, `COP_A_TXTB2, `COP_A_TXTB3: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // apb control registers
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_r  <= 3'h0;
            page_r  <= 4'h0;
            dest_r  <= 1'b0;
            ie_r    <= 1'b0;
            mark_r  <= 1'b0;
            txtc_r  <= 64'h0;
            ien_r   <= 4'h0;
        end else if (i_module_disable) begin
            ctrl_r  <= 3'h0;
            page_r  <= 4'h0;
            dest_r  <= 1'b0;
            ie_r    <= 1'b0;
            ien_r   <= 4'h0;
        end else if (wr_acc) begin
            case (i_paddr)
                `COP_A_CTRL:  ctrl_r <= i_pwdata[2:0];
                `COP_A_OTP: begin
                    page_r <= i_pwdata[`COP_OTP_PG_MSB:`COP_OTP_PG_LSB];
                    dest_r <= i_pwdata[`COP_OTP_DEST];
                    ie_r   <= i_pwdata[`COP_OTP_IE];
                    if (i_pwdata[`COP_OTP_MARK])
                        mark_r <= 1'b1;
                end
                `COP_A_TXTC0: txtc_r[31:0]  <= i_pwdata;
                `COP_A_TXTC1: txtc_r[63:32] <= i_pwdata;
                `COP_A_IEN:   ien_r <= i_pwdata[3:0];
                default: ;
            endcase
        end
    end

    // control high: wipe bit is set-only and cleared by the sequencer
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            conh_r <= `COP_CONH_RST;
        end else if (i_module_disable) begin
            conh_r <= `COP_CONH_RST;
        end else begin
            if (wr_conh)
                conh_r <= (i_pwdata[15:0] & `COP_CONH_WMASK) | (conh_r & ~`COP_CONH_WMASK);
            if (wr_conh & i_pwdata[`COP_CH_WIPE])
                conh_r[`COP_CH_WIPE] <= 1'b1;
            else if (state_r == ST_WIPE && step_r[1:0] == `COP_KEY_WORDS)
                conh_r[`COP_CH_WIPE] <= 1'b0;
        end
    end

    // go bits: set by software, cleared only by hardware
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_go_r <= 1'b0;
            rd_go_r <= 1'b0;
        end else if (i_module_disable) begin
            wr_go_r <= 1'b0;
            rd_go_r <= 1'b0;
        end else begin
            if (wr_otp & i_pwdata[`COP_OTP_WR] & ~fail & ~wr_go_r)
                wr_go_r <= 1'b1;
            else if (state_r == ST_PROG && cnt_r == 16'h0001)
                wr_go_r <= 1'b0;
            if (wr_otp & i_pwdata[`COP_OTP_RD] & en & ~wr_go_r)
                rd_go_r <= 1'b1;
            else if (state_r == ST_LOAD && ~en)
                rd_go_r <= 1'b0;
            else if (state_r == ST_LOAD && cnt_r == 16'h0001 && step_r == `COP_KEY_PAGES)
                rd_go_r <= 1'b0;
        end
    end

    // a blank array reads as zeros; programming can only turn bits on, so an unknown start would poison the or
    initial begin
        for (blank_i = 0; blank_i < 2*PAGES; blank_i = blank_i + 1) begin
            otp_mem[blank_i] = 64'h0;
        end
    end

    // sequencer; the otp array itself is not reset, being nonvolatile
    always @(posedge i_clk) begin
        if (state_r == ST_PROG && cnt_r == 16'h0001) begin
            if (is_cfg)
                otp_mem[addr_r] <= otp_mem[addr_r] | {32'h0000_0000, txtc_r[31:0]};
            else
                otp_mem[addr_r] <= otp_mem[addr_r] | txtc_r;
        end
    end

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r     <= ST_IDLE;
            cnt_r       <= 16'h0000;
            step_r      <= 3'h0;
            addr_r      <= 5'h00;
            cfg_r       <= 32'h0000_0000;
            o_key_valid <= 1'b0;
            key_r[0]    <= 64'h0;
            key_r[1]    <= 64'h0;
            key_r[2]    <= 64'h0;
            key_r[3]    <= 64'h0;
        end else if (i_module_disable) begin
            state_r     <= ST_IDLE;
            cnt_r       <= 16'h0000;
            step_r      <= 3'h0;
            o_key_valid <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    step_r <= 3'h0;
                    if (conh_r[`COP_CH_WIPE]) begin
                        state_r     <= ST_WIPE;
                        o_key_valid <= 1'b0;
                    end else if (wr_go_r) begin
                        state_r <= ST_PROG;
                        cnt_r   <= PROG_CYC[15:0];
                        addr_r  <= {dest_r, page_r};
                    end else if (rd_go_r) begin
                        state_r     <= ST_LOAD;
                        cnt_r       <= READ_CYC[15:0];
                        addr_r      <= {dest_r, `COP_PAGE_CFG};
                        o_key_valid <= 1'b0;
                    end
                end
                ST_PROG: begin
                    cnt_r <= cnt_r - 16'h0001;
                    if (cnt_r == 16'h0001)
                        state_r <= ST_IDLE;
                end
                ST_LOAD: begin
                    if (~en) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                        if (cnt_r == 16'h0001) begin
                            if (step_r == 3'h0)
                                cfg_r <= otp_mem[addr_r][31:0];
                            else
                                key_r[step_r[1:0] - 2'h1] <= otp_mem[addr_r];
                            if (step_r == `COP_KEY_PAGES) begin
                                state_r     <= ST_IDLE;
                                o_key_valid <= 1'b1;
                            end else begin
                                step_r <= step_r + 3'h1;
                                addr_r <= addr_r + 5'h01;
                                cnt_r  <= READ_CYC[15:0];
                            end
                        end
                    end
                end
                ST_WIPE: begin
                    key_r[step_r[1:0]] <= 64'h0;
                    step_r <= step_r + 3'h1;
                    if (step_r[1:0] == `COP_KEY_WORDS)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // counter over text B; width only matters in counter mode
    always @* begin
        ctr_mask = ~({TXTB_W{1'b1}} << ({1'b0, conh_r[`COP_CH_CTR_MSB:`COP_CH_CTR_LSB]} + 8'h01));
        txtb_nxt = (o_text_b & ~ctr_mask) | ((o_text_b + {{(TXTB_W-1){1'b0}}, 1'b1}) & ctr_mask);
    end

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_text_b <= {TXTB_W{1'b0}};
        end else if (wr_acc && i_paddr == `COP_A_TXTB0) begin
            o_text_b[31:0] <= i_pwdata;
        end else if (wr_acc && i_paddr == `COP_A_TXTB1) begin
            o_text_b[63:32] <= i_pwdata;
        end else if (wr_acc && i_paddr == `COP_A_TXTB2) begin
            o_text_b[95:64] <= i_pwdata;
        end else if (wr_acc && i_paddr == `COP_A_TXTB3) begin
            o_text_b[127:96] <= i_pwdata;
        end else if (ctr_mode & i_block_done) begin
            o_text_b <= txtb_nxt;
        end
    end

    always @* begin
        ev = 4'h0;
        ev[`COP_EV_WR]   = (state_r == ST_PROG) && (cnt_r == 16'h0001);
        ev[`COP_EV_RD]   = (state_r == ST_LOAD) && en && (cnt_r == 16'h0001) && (step_r == `COP_KEY_PAGES);
        ev[`COP_EV_ROLL] = ctr_mode & i_block_done & ((o_text_b & ctr_mask) == ctr_mask);
        ev[`COP_EV_WIPE] = (state_r == ST_WIPE) && (step_r[1:0] == `COP_KEY_WORDS);
    end

    // set wins over a clear in the same cycle
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            istat_r <= 4'h0;
        else if (wr_acc && i_paddr == `COP_A_ICLR)
            istat_r <= (istat_r & ~i_pwdata[3:0]) | ev;
        else
            istat_r <= istat_r | ev;
    end

    // key length decode and key half; registered so the datapath sees stable values
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_session_key      <= 128'h0;
            o_key_source       <= 4'h0;
            o_aes_key_bits     <= 9'h000;
            o_des_key_count    <= 2'h0;
            o_key_len_reserved <= 1'b0;
        end else begin
            if (conh_r[`COP_CH_SKEY])
                o_session_key <= {key_r[3], key_r[2]};
            else
                o_session_key <= {key_r[1], key_r[0]};
            o_key_source <= conh_r[`COP_CH_KS_MSB:`COP_CH_KS_LSB];
            o_aes_key_bits     <= 9'h000;
            o_des_key_count    <= 2'h0;
            o_key_len_reserved <= 1'b0;
            if (ctrl_r[`COP_CTRL_CIPH]) begin
                case (conh_r[`COP_CH_KM_MSB:`COP_CH_KM_LSB])
                    2'h0: o_aes_key_bits <= 9'h080;
                    2'h1: o_aes_key_bits <= 9'h0C0;
                    2'h2: o_aes_key_bits <= 9'h100;
                    default: o_key_len_reserved <= 1'b1;
                endcase
            end else begin
                case (conh_r[`COP_CH_KM_MSB:`COP_CH_KM_LSB])
                    2'h0: o_des_key_count <= 2'h1;
                    2'h1: o_des_key_count <= 2'h2;
                    2'h3: o_des_key_count <= 2'h3;
                    default: o_key_len_reserved <= 1'b1;
                endcase
            end
        end
    end

    // read data registered in the setup phase so it is stable when the master samples in the access phase
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel & ~i_penable & ~i_pwrite) begin
            o_prdata <= 32'h0000_0000;
            case (i_paddr)
                `COP_A_CTRL:  o_prdata[2:0] <= ctrl_r;
                `COP_A_CONH:  o_prdata[15:0] <= conh_r;
                `COP_A_OTP:   o_prdata[11:0] <= {o_otp_busy, fail, 1'b0, dest_r, mark_r, ie_r,
                                                 rd_go_r, wr_go_r, page_r};
                `COP_A_TXTC0: o_prdata <= txtc_r[31:0];
                `COP_A_TXTC1: o_prdata <= txtc_r[63:32];
                `COP_A_ISTAT: o_prdata[3:0] <= istat_r;
                `COP_A_IEN:   o_prdata[3:0] <= ien_r;
                `COP_A_CFG:   o_prdata <= cfg_r;
                `COP_A_TXTB0: o_prdata <= o_text_b[31:0];
                `COP_A_TXTB1: o_prdata <= o_text_b[63:32];
                `COP_A_TXTB2: o_prdata <= o_text_b[95:64];
                `COP_A_TXTB3: o_prdata <= o_text_b[127:96];
                default: ;
            endcase
        end
    end
endmodule // cop_top
`default_nettype wire
